// ---- src/fetx_pkg.sv ----
// Constants, types and code table for the 100 Mb/s transmit coding path.
// Assumes a single 250 MHz system clock and a 125 Mb/s line rate.
package fetx_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ    = 250;
    localparam int LINE_RATE_MBPS = 125;
    localparam int TICK_DIV       = SYS_CLK_MHZ / LINE_RATE_MBPS;
    localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);
    localparam logic [1:0] SEED_WAIT = 2'h3;

    // ------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------
    localparam int NIB_W   = 4;
    localparam int GRP_W   = 5;
    localparam int LFSR_W  = 11;
    localparam int TAP_A   = 10;
    localparam int TAP_B   = 8;
    localparam int ADDR_HI = 4;
    localparam int ADDR_LO = 1;
    localparam int WORD_W  = NIB_W + 2;
    localparam int EN_BIT  = NIB_W;
    localparam int ER_BIT  = NIB_W + 1;
    localparam logic [2:0] BIT_LAST = 3'h4;
    localparam logic [6:0] SEED_LOW = 7'h55;
    localparam logic [10:0] LFSR_RST = 11'h7FF;

    // ------------------------------------------------------------
    // Control code-groups and decoded nibbles
    // ------------------------------------------------------------
    localparam logic [4:0] CG_IDLE = 5'h1F;
    localparam logic [4:0] CG_J    = 5'h18;
    localparam logic [4:0] CG_K    = 5'h11;
    localparam logic [4:0] CG_T    = 5'h0D;
    localparam logic [4:0] CG_R    = 5'h07;
    localparam logic [4:0] CG_H    = 5'h04;
    localparam logic [3:0] NIB_SSD  = 4'h5;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [3:0] NIB_BAD  = 4'hE;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_K    = 2'b01,
        ST_DATA = 2'b10,
        ST_R    = 2'b11
    } fetx_state_t;

    // Nibble to data code-group
    function automatic logic [4:0] fetx_enc(input logic [3:0] n);
        case (n)
            4'h0: fetx_enc = 5'h1E;
            4'h1: fetx_enc = 5'h09;
            4'h2: fetx_enc = 5'h14;
            4'h3: fetx_enc = 5'h15;
            4'h4: fetx_enc = 5'h0A;
            4'h5: fetx_enc = 5'h0B;
            4'h6: fetx_enc = 5'h0E;
            4'h7: fetx_enc = 5'h0F;
            4'h8: fetx_enc = 5'h12;
            4'h9: fetx_enc = 5'h13;
            4'hA: fetx_enc = 5'h16;
            4'hB: fetx_enc = 5'h17;
            4'hC: fetx_enc = 5'h1A;
            4'hD: fetx_enc = 5'h1B;
            4'hE: fetx_enc = 5'h1C;
            default: fetx_enc = 5'h1D;
        endcase
    endfunction

    // Code-group to {error, nibble}
    function automatic logic [4:0] fetx_dec(input logic [4:0] g,
                                             input logic in_data);
        logic [4:0] r;
        r = {1'b1, NIB_BAD};
        for (int i = 0; i < 16; i++) begin
            if (fetx_enc(4'(i)) == g)
                r = {1'b0, 4'(i)};
        end
        if (!in_data && (g == CG_J || g == CG_K))
            r = {1'b0, NIB_SSD};
        if (!in_data && (g == CG_IDLE || g == CG_T || g == CG_R))
            r = {1'b0, NIB_ZERO};
        return r;
    endfunction

endpackage

// ---- src/fetx_coder.sv ----
// Transmit coding path: 4B/5B encoder, scrambler, NRZI and MLT-3 split,
// plus the 5B to 4B decode table.
// Assumes the MAC stream is on sys_clk; straps and bypass are pins.
`timescale 1ns/100ps
module fetx_coder #(
    parameter int BUF_DEPTH = 2,
    parameter int BUF_WIDTH = fetx_pkg::WORD_W
) (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        reset,
    // MAC transmit stream
    input  wire logic                        mac_valid,
    output logic                             mac_ready,
    input  wire logic [fetx_pkg::NIB_W-1:0]  mac_txd,
    input  wire logic                        mac_tx_en,
    input  wire logic                        mac_tx_er,
    // Strap and option pins
    input  wire logic [4:0]                  station_addr_pins,
    input  wire logic                        scr_bypass,
    // Line drive streams
    output logic                             mlt_pos,
    output logic                             mlt_neg,
    // Decode direction
    input  wire logic                        rx_group_valid,
    input  wire logic [fetx_pkg::GRP_W-1:0]  rx_group,
    input  wire logic                        rx_in_data,
    output logic                             rx_nibble_valid,
    output logic [fetx_pkg::NIB_W-1:0]       rx_nibble,
    output logic                             rx_err
);
    import fetx_pkg::*;

    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);

    logic [5:0]             pin_s1;
    logic [5:0]             pin_s2;
    logic [5:0]             pin_s3;
    logic [5:0]             pin_f;
    logic [5:0]             pin_next;
    logic [1:0]             tick_cnt;
    logic                   sym_tick;
    logic [1:0]             seed_cnt;
    logic                   seeded;
    logic [LFSR_W-1:0]      lfsr;
    logic                   key;
    logic [BUF_WIDTH-1:0]   buf_mem [BUF_DEPTH];
    logic [PTR_W-1:0]       wr_ptr;
    logic [PTR_W-1:0]       rd_ptr;
    logic [CNT_W-1:0]       buf_cnt;
    logic                   buf_valid;
    logic [BUF_WIDTH-1:0]   buf_word;
    logic                   buf_pop;
    logic                   buf_push;
    fetx_state_t            state;
    fetx_state_t            next_state;
    logic [GRP_W-1:0]       next_group;
    logic                   next_pop;
    logic [GRP_W-1:0]       shreg;
    logic [2:0]             bit_cnt;
    logic                   load;
    logic                   code_bit;
    logic                   scr_bit;
    logic                   nrzi;
    logic [1:0]             mlt_phase;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_s1 <= 6'h00;
            pin_s2 <= 6'h00;
            pin_s3 <= 6'h00;
            pin_f  <= 6'h00;
        end else begin
            pin_s1 <= {scr_bypass, station_addr_pins};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f  <= pin_next;
        end
    end

    // Value the filter takes at this edge; the seed load reads it too
    assign pin_next = (pin_s3 & ~(pin_s2 ^ pin_s3))
                    | (pin_f & (pin_s2 ^ pin_s3));

    // ------------------------------------------------------------
    // Symbol tick divider
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset || sym_tick)
            tick_cnt <= 2'h0;
        else
            tick_cnt <= tick_cnt + 2'h1;
    end

    assign sym_tick = (tick_cnt == TICK_LAST);

    // ------------------------------------------------------------
    // Two-entry input buffer
    // ------------------------------------------------------------
    assign mac_ready = (buf_cnt != CNT_W'(BUF_DEPTH));
    assign buf_push  = mac_valid && mac_ready;
    assign buf_valid = (buf_cnt != '0);
    assign buf_word  = buf_mem[rd_ptr];
    assign buf_pop   = load && next_pop;

    always_ff @(posedge sys_clk) begin
        if (buf_push)
            buf_mem[wr_ptr] <= {mac_tx_er, mac_tx_en, mac_txd};
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            buf_cnt <= '0;
        end else begin
            if (buf_push)
                wr_ptr <= (wr_ptr == PTR_W'(BUF_DEPTH - 1)) ?
                          '0 : wr_ptr + PTR_W'(1);
            if (buf_pop)
                rd_ptr <= (rd_ptr == PTR_W'(BUF_DEPTH - 1)) ?
                          '0 : rd_ptr + PTR_W'(1);
            buf_cnt <= buf_cnt + CNT_W'(buf_push) - CNT_W'(buf_pop);
        end
    end

    // ------------------------------------------------------------
    // Code-group sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_group = CG_IDLE;
        next_pop   = 1'b0;
        case (state)
            ST_IDLE: begin
                if (buf_valid && buf_word[EN_BIT]) begin
                    next_group = CG_J;
                    next_pop   = 1'b1;
                    next_state = ST_K;
                end else begin
                    next_group = CG_IDLE;
                    next_pop   = buf_valid;
                end
            end
            ST_K: begin
                next_group = CG_K;
                next_pop   = buf_valid && buf_word[EN_BIT];
                next_state = ST_DATA;
            end
            ST_DATA: begin
                if (!buf_valid) begin
                    next_group = CG_H;
                end else if (!buf_word[EN_BIT]) begin
                    next_group = CG_T;
                    next_state = ST_R;
                end else if (buf_word[ER_BIT]) begin
                    next_group = CG_H;
                    next_pop   = 1'b1;
                end else begin
                    next_group = fetx_enc(buf_word[NIB_W-1:0]);
                    next_pop   = 1'b1;
                end
            end
            ST_R: begin
                next_group = CG_R;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset)
            state <= ST_IDLE;
        else if (load)
            state <= next_state;
    end

    // ------------------------------------------------------------
    // Serialiser
    // ------------------------------------------------------------
    assign load     = sym_tick && (bit_cnt == BIT_LAST);
    assign code_bit = shreg[GRP_W-1];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shreg   <= CG_IDLE;
            bit_cnt <= 3'h0;
        end else if (load) begin
            shreg   <= next_group;
            bit_cnt <= 3'h0;
        end else if (sym_tick) begin
            shreg   <= {shreg[GRP_W-2:0], 1'b0};
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Scrambler
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            seed_cnt <= 2'h0;
            seeded   <= 1'b0;
        end else if (!seeded) begin
            seed_cnt <= seed_cnt + 2'h1;
            seeded   <= (seed_cnt == SEED_WAIT);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset)
            lfsr <= LFSR_RST;
        else if (!seeded && seed_cnt == SEED_WAIT)
            lfsr <= {pin_next[ADDR_HI:ADDR_LO], SEED_LOW};
        else if (sym_tick)
            lfsr <= {lfsr[LFSR_W-2:0],
                     lfsr[TAP_A] ^ lfsr[TAP_B]};
    end

    assign key     = lfsr[TAP_A] & ~pin_f[5];
    assign scr_bit = code_bit ^ key;

    // ------------------------------------------------------------
    // NRZI and MLT-3 split
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset)
            nrzi <= 1'b0;
        else if (sym_tick)
            nrzi <= nrzi ^ scr_bit;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mlt_phase <= 2'h0;
            mlt_pos   <= 1'b0;
            mlt_neg   <= 1'b0;
        end else if (sym_tick) begin
            mlt_phase <= mlt_phase + 2'(scr_bit);
            mlt_pos   <= scr_bit && mlt_phase == 2'h0;
            mlt_neg   <= scr_bit && mlt_phase == 2'h2;
        end
    end

    // ------------------------------------------------------------
    // Decode direction
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_nibble_valid <= 1'b0;
            rx_nibble       <= NIB_ZERO;
            rx_err          <= 1'b0;
        end else begin
            rx_nibble_valid <= rx_group_valid;
            if (rx_group_valid)
                {rx_err, rx_nibble} <=
                    fetx_dec(rx_group, rx_in_data);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence start_seq;
        load && next_group == CG_J;
    endsequence

    sequence end_seq;
        load && next_group == CG_T;
    endsequence

    tick_rate_a: assert property (
        sym_tick |=> !sym_tick ##1 sym_tick)
        else $error("symbol tick not every second cycle");

    jk_pair_a: assert property (
        start_seq |-> ##10 (load && next_group == CG_K))
        else $error("J not followed by K");

    tr_pair_a: assert property (
        end_seq |-> ##10 (load && next_group == CG_R)
        ##10 (load && state == ST_IDLE))
        else $error("T not followed by R then idle");

    data_map_a: assert property (
        load && state == ST_DATA && buf_valid && buf_word[EN_BIT]
        && !buf_word[ER_BIT] |=>
        shreg == fetx_enc($past(buf_word[NIB_W-1:0])))
        else $error("data nibble encoded wrongly");

    halt_err_a: assert property (
        load && state == ST_DATA && buf_valid && buf_word[ER_BIT]
        && buf_word[EN_BIT] |=> shreg == CG_H)
        else $error("error nibble not sent as halt");

    idle_fill_a: assert property (
        load && state == ST_IDLE && !(buf_valid && buf_word[EN_BIT])
        |=> shreg == CG_IDLE)
        else $error("idle fill missing");

    bypass_a: assert property (
        pin_f[5] |-> scr_bit == code_bit)
        else $error("bypass still scrambles");

    nrzi_a: assert property (
        sym_tick |=> (nrzi != $past(nrzi)) == $past(scr_bit))
        else $error("NRZI level wrong");

    mlt_excl_a: assert property (
        !(mlt_pos && mlt_neg))
        else $error("both drive streams active");

    lfsr_live_a: assert property (
        lfsr != '0)
        else $error("scrambler locked at zero");

    decode_ssd_a: assert property (
        rx_group_valid && !rx_in_data && rx_group == CG_J
        |=> rx_nibble == NIB_SSD && !rx_err && rx_nibble_valid)
        else $error("start delimiter decoded wrongly");

    decode_bad_a: assert property (
        rx_group_valid && rx_in_data && rx_group == CG_IDLE
        |=> rx_err)
        else $error("control group in data not flagged");

    buf_full_a: assert property (
        buf_cnt == CNT_W'(BUF_DEPTH) |-> !mac_ready)
        else $error("buffer accepts when full");

endmodule

// ---- sim/fetx_mac_model.sv ----
// MAC-side stream model: offers queued words over valid/ready.
// Assumes words are {tx_er, tx_en, nibble} as laid out in fetx_pkg.
`timescale 1ns/100ps
module fetx_mac_model (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        reset,
    // Stream towards the coder
    input  wire logic                        mac_ready,
    output logic                             mac_valid,
    output logic [fetx_pkg::NIB_W-1:0]       mac_txd,
    output logic                             mac_tx_en,
    output logic                             mac_tx_er
);
    import fetx_pkg::*;

    logic [WORD_W-1:0] q[$];

    function automatic int pending();
        return q.size();
    endfunction

    task automatic put(input logic [WORD_W-1:0] d);
        q.push_back(d);
    endtask

    // Word held until a ready edge takes it; released lines toggle
    always @(posedge sys_clk) begin
        if (reset) begin
            mac_valid <= 1'b0;
            mac_txd   <= 4'h0;
            mac_tx_en <= 1'b0;
            mac_tx_er <= 1'b0;
        end else if (!mac_valid || mac_ready) begin
            if (q.size() > 0) begin
                mac_valid <= 1'b1;
                mac_txd   <= q[0][NIB_W-1:0];
                mac_tx_en <= q[0][EN_BIT];
                mac_tx_er <= q[0][ER_BIT];
                q.delete(0);
            end else begin
                mac_valid <= 1'b0;
                mac_txd   <= ~mac_txd;
                mac_tx_en <= ~mac_tx_en;
                mac_tx_er <= ~mac_tx_er;
            end
        end
    end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the transmit coding path and decode table.
// Assumes the MAC model drives the stream; line read from pulse gaps.
`timescale 1ns/100ps
module tb;
    import fetx_pkg::*;

    localparam int NG = 30;
    localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15,
        5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17,
        5'h1A, 5'h1B, 5'h1C, 5'h1D};

    logic        sys_clk;
    logic        reset;
    logic        mac_valid;
    logic        mac_ready;
    logic [3:0]  mac_txd;
    logic        mac_tx_en;
    logic        mac_tx_er;
    logic [4:0]  station_addr_pins;
    logic        scr_bypass;
    logic        mlt_pos;
    logic        mlt_neg;
    logic        rx_group_valid;
    logic [4:0]  rx_group;
    logic        rx_in_data;
    logic        rx_nibble_valid;
    logic [3:0]  rx_nibble;
    logic        rx_err;
    int          n_errors;
    int          n_compared;
    logic        saw_full;
    int          edges[$];
    logic        pols[$];
    int          og[$];
    int          eg[$];
    logic        exp_bits[$];
    logic [31:0] h0;
    logic [31:0] h1;
    logic [31:0] h2;

    fetx_mac_model u_mac (.sys_clk(sys_clk), .reset(reset),
        .mac_ready(mac_ready), .mac_valid(mac_valid), .mac_txd(mac_txd),
        .mac_tx_en(mac_tx_en), .mac_tx_er(mac_tx_er));

    fetx_coder u_dut (.sys_clk(sys_clk), .reset(reset),
        .mac_valid(mac_valid), .mac_ready(mac_ready), .mac_txd(mac_txd),
        .mac_tx_en(mac_tx_en), .mac_tx_er(mac_tx_er),
        .station_addr_pins(station_addr_pins), .scr_bypass(scr_bypass),
        .mlt_pos(mlt_pos), .mlt_neg(mlt_neg),
        .rx_group_valid(rx_group_valid), .rx_group(rx_group),
        .rx_in_data(rx_in_data), .rx_nibble_valid(rx_nibble_valid),
        .rx_nibble(rx_nibble), .rx_err(rx_err));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic run_reset(input logic [4:0] pins, input logic byp);
        @(posedge sys_clk);
        reset <= 1'b1;
        station_addr_pins <= pins;
        scr_bypass <= byp;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        check("ready_rst", mac_ready, 1);
        check("mlt_rst", {mlt_pos, mlt_neg}, 0);
        check("rx_rst", {rx_nibble_valid, rx_err, rx_nibble}, 0);
    endtask

    // Pulse start cycles of both drive streams
    task automatic record(input int n);
        logic lp;
        logic ln;
        edges.delete();
        pols.delete();
        lp = mlt_pos;
        ln = mlt_neg;
        for (int c = 0; c < n; c++) begin
            @(negedge sys_clk);
            if (mac_ready === 1'b0)
                saw_full = 1'b1;
            check("mlt_both", mlt_pos & mlt_neg, 0);
            if ((mlt_pos & !lp) === 1'b1 || (mlt_neg & !ln) === 1'b1) begin
                if (pols.size() > 0)
                    check("mlt_alt", mlt_pos, !pols[$]);
                edges.push_back(c);
                pols.push_back(mlt_pos);
            end
            lp = mlt_pos;
            ln = mlt_neg;
        end
    endtask

    task automatic push_grp(input logic [4:0] g);
        for (int i = 4; i >= 0; i--)
            exp_bits.push_back(g[i]);
    endtask

    // Pulse gaps in cycles for ones of parity p, leading idle dropped
    task automatic exp_gaps(input int p);
        int ones[$];
        eg.delete();
        for (int i = 0; i < exp_bits.size(); i++)
            if (exp_bits[i] === 1'b1)
                ones.push_back(i);
        for (int j = p; j + 2 < ones.size(); j += 2)
            if (eg.size() > 0 || ones[j+2] - ones[j] != 2)
                eg.push_back(2 * (ones[j+2] - ones[j]));
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_decode();
        logic [4:0] e;
        logic [4:0] g;
        for (int d = 0; d < 2; d++) begin
            for (int k = 0; k < 32; k++) begin
                g = 5'(k);
                e = {1'b1, NIB_BAD};
                for (int n = 0; n < 16; n++)
                    if (ENC[n] == g)
                        e = {1'b0, 4'(n)};
                if (d == 0 && (g == CG_J || g == CG_K))
                    e = {1'b0, NIB_SSD};
                if (d == 0 && (g == CG_IDLE || g == CG_T || g == CG_R))
                    e = {1'b0, NIB_ZERO};
                @(posedge sys_clk);
                rx_group_valid <= 1'b1;
                rx_group <= g;
                rx_in_data <= d[0];
                @(negedge sys_clk);
                check("dec_wait", rx_nibble_valid, 0);
                @(posedge sys_clk);
                rx_group_valid <= 1'b0;
                @(negedge sys_clk);
                check("dec_valid", rx_nibble_valid, 1);
                check("dec_out", {rx_err, rx_nibble}, e);
            end
        end
        $display("test decode done");
    endtask

    task automatic t_frame();
        exp_bits.delete();
        push_grp(CG_IDLE);
        push_grp(CG_IDLE);
        push_grp(CG_J);
        push_grp(CG_K);
        push_grp(ENC[5]);
        push_grp(ENC[13]);
        for (int n = 0; n < 16; n++)
            push_grp(n == 9 ? CG_H : ENC[n]);
        push_grp(CG_T);
        push_grp(CG_R);
        repeat (5) push_grp(CG_IDLE);
        @(negedge sys_clk);
        repeat (3) u_mac.put(6'h15);
        u_mac.put(6'h1D);
        for (int n = 0; n < 16; n++)
            u_mac.put({n == 9, 1'b1, 4'(n)});
        u_mac.put(6'h00);
        saw_full = 1'b0;
        record(700);
        check("buf_full", saw_full, 1);
        check("mac_drain", u_mac.pending(), 0);
        if (u_mac.pending() != 0)
            tally_and_finish();
        og.delete();
        for (int i = 1; i < edges.size(); i++)
            if (og.size() > 0 || edges[i] - edges[i-1] != 4)
                og.push_back(edges[i] - edges[i-1]);
        exp_gaps(1);
        if (og.size() < 3 || eg.size() < 3 || og[0] != eg[0]
            || og[1] != eg[1] || og[2] != eg[2])
            exp_gaps(0);
        check("gap_count", og.size() >= NG && eg.size() >= NG, 1);
        for (int i = 0; i < NG && i < og.size() && i < eg.size(); i++)
            check("pulse_gap", og[i], eg[i]);
        $display("test frame done");
    endtask

    task automatic sig(input logic [4:0] pins, output logic [31:0] h);
        int odd;
        run_reset(pins, 1'b0);
        record(600);
        h = 32'h0;
        odd = 0;
        for (int i = 0; i < edges.size(); i++) begin
            h = (h * 33) ^ 32'(edges[i]);
            if (i > 0 && edges[i] - edges[i-1] != 4)
                odd++;
        end
        check("scr_active", odd > 0, 1);
    endtask

    task automatic t_seed();
        sig(5'h06, h0);
        sig(5'h07, h1);
        sig(5'h17, h2);
        check("seed_lsb", h1, h0);
        check("seed_hi", h2 !== h0, 1);
        $display("test seed done");
    endtask

    initial begin
        reset = 1'b1;
        station_addr_pins = 5'h00;
        scr_bypass = 1'b1;
        rx_group_valid = 1'b0;
        rx_group = 5'h00;
        rx_in_data = 1'b0;
        n_errors = 0;
        n_compared = 0;
        saw_full = 1'b0;
        run_reset(5'h0A, 1'b1);
        t_decode();
        t_frame();
        t_seed();
        tally_and_finish();
    end
endmodule
